/* File: hw/cng_pkg.sv */
// package of the node guard monitor: object indices, field widths, reset values, timing
// assumes a single 250 MHz core clock shared by every user of these constants
package cng_pkg;

  // core clock and the millisecond base of the guard interval
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // object dictionary indices
  localparam logic [15:0] IDX_GUARD_INTERVAL = 16'h100c;
  localparam logic [15:0] IDX_GUARD_MULT = 16'h100d;
  localparam logic [15:0] IDX_PEER_BEAT = 16'h1016;
  localparam logic [15:0] IDX_BEAT_SEND = 16'h1017;
  localparam logic [15:0] IDX_CUR_LIMIT = 16'h2056;
  localparam logic [15:0] IDX_LINK_WATCH = 16'h2066;
  localparam logic [15:0] IDX_DRIVE_FIRST = 16'h2000;
  localparam logic [15:0] IDX_DRIVE_LAST = 16'h2200;

  // subindices
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_PEER_ENTRY = 8'h01;
  localparam logic [31:0] PEER_BEAT_COUNT = 32'h0000_0001;

  // reset values
  localparam logic [15:0] RST_GUARD_INTERVAL = 16'h0000;
  localparam logic [7:0] RST_GUARD_MULT = 8'h00;
  localparam logic [31:0] RST_PEER_BEAT = 32'h0000_0000;
  localparam logic [15:0] RST_BEAT_SEND = 16'h0000;
  localparam logic [31:0] RST_CUR_LIMIT = 32'h0000_0000;
  localparam logic [31:0] RST_LINK_WATCH = 32'h0000_0000;

  // single precision payloads
  localparam int FLT_SIGN = 31;
  localparam logic [31:0] FLT_ZERO = 32'h0000_0000;
  localparam logic [31:0] FLT_CUR_LIMIT_MAX = 32'h437a_0000;

  // guard frames
  localparam logic [10:0] GUARD_COB_BASE = 11'h700;
  localparam logic [3:0] GUARD_QUERY_DLC = 4'h0;
  localparam int TOGGLE_BIT = 7;

  // window product widths
  localparam int WIN_W = 24;

endpackage

/* File: hw/cng_timer_if.sv */
// link between the guard monitor and its supervision window timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface cng_timer_if;
  import cng_pkg::*;
  logic run;
  logic kick;
  logic [WIN_W-1:0] window_ms;
  logic expire;
  modport ctrl (output run, output kick, output window_ms, input expire);
  modport timer (input run, input kick, input window_ms, output expire);
endinterface
`default_nettype wire

/* File: hw/cng_guard_timer.sv */
// supervision window timer: millisecond divider and window counter
// assumes kick and run come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module cng_guard_timer
  import cng_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  cng_timer_if.timer tif
);

  typedef struct packed {
    logic [31:0] div;
    logic [WIN_W-1:0] ms;
    logic done;
    logic expire;
  } cng_tmr_st_t;

  cng_tmr_st_t s_q;
  cng_tmr_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (!tif.run || tif.kick) begin
      // every valid query restarts the whole window
      s_d.div = '0;
      s_d.ms = '0;
      s_d.done = 1'b0;
    end else if (!s_q.done) begin
      if (s_q.div == 32'(TICK_CYCLES - 1)) begin
        s_d.div = '0;
        s_d.ms = s_q.ms + 1'b1;
        if (s_q.ms + 1'b1 == tif.window_ms) begin
          // fires once, then waits for the next kick
          s_d.expire = 1'b1;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.div = s_q.div + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.expire = s_q.expire;

endmodule
`default_nettype wire

/* File: hw/cng_node_guard.sv */
// node guard monitor: guard replies, supervision arming and timeout, parameter objects
// assumes the frame and object ports are driven by logic on CORE_CLK
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - parameter objects accessed through process data are refused with an abort
// - accepted writes to current limit and bus supervision parameter are committed to non-volatile storage; master limits writes
// - parameter payloads are single precision floating point values on both sides
// - current limit percent at 0x2056, writable any time, bounded 0 to 250
// - guarding runs only while heartbeat producer period is zero, its reset value
// - guarding also needs heartbeat consumer entry one zero, its reset value
// - guard interval must be non-zero and counts milliseconds
// - life time factor must be non-zero; it counts guard intervals to timeout
// - timeout error only when bus supervision parameter non-zero; acts as enable only
// - supervision window is guard interval times life time factor
// - master polls by data-less remote frame on 0x700 plus node; first arms timer
// - each query answered with one byte unless a reply still waits: state in low seven bits, toggle in bit 7
// - missing query in window raises bus timeout, error state, motor stop
// - bus timeout error can be acknowledged immediately after it is raised
module cng_node_guard
  import cng_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [6:0] NODE_ID,
  input wire logic [6:0] NODE_STATE,
  input wire logic RX_VALID,
  input wire logic [10:0] RX_ID,
  input wire logic RX_RTR,
  input wire logic [3:0] RX_DLC,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [10:0] TX_ID,
  output logic [7:0] TX_DATA,
  input wire logic OBJ_REQ,
  input wire logic OBJ_WR,
  input wire logic OBJ_PDO,
  input wire logic [15:0] OBJ_IDX,
  input wire logic [7:0] OBJ_SUB,
  input wire logic [31:0] OBJ_WDATA,
  output logic OBJ_ACK,
  output logic OBJ_ABORT,
  output logic [31:0] OBJ_RDATA,
  output logic NVM_WR,
  output logic [15:0] NVM_IDX,
  output logic [31:0] NVM_DATA,
  input wire logic ERR_ACK,
  output logic BUS_TMO_ERR,
  output logic MOTOR_STOP,
  output logic GUARD_ARMED
);

  typedef struct packed {
    logic [15:0] guard_interval_ms;
    logic [7:0] guard_multiplier;
    logic [31:0] peer_beat_watch_cfg;
    logic [15:0] beat_send_period;
    logic [31:0] motor_current_limit_pct;
    logic [31:0] link_watch_enable;
    logic armed;
    logic run;
    logic kick;
    logic toggle;
    logic tmo_err;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [7:0] tx_data;
    logic obj_ack;
    logic obj_abort;
    logic [31:0] obj_rdata;
    logic nvm_wr;
    logic [15:0] nvm_idx;
    logic [31:0] nvm_data;
  } cng_st_t;

  cng_st_t s_q;
  cng_st_t s_d;

  cng_timer_if tif ();

  cng_guard_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .tif(tif)
  );

  // sign ignored; any exponent or mantissa bit means a non-zero real
  function automatic logic flt_nonzero(input logic [31:0] f);
    flt_nonzero = (f[FLT_SIGN-1:0] != FLT_ZERO[FLT_SIGN-1:0]);
  endfunction

  // positive reals order like unsigned integers, so a plain compare bounds them
  function automatic logic [31:0] flt_clamp(input logic [31:0] f, input logic [31:0] hi);
    if (f[FLT_SIGN]) begin
      flt_clamp = FLT_ZERO;
    end else if (f > hi) begin
      flt_clamp = hi;
    end else begin
      flt_clamp = f;
    end
  endfunction

  // guard query and reply share one identifier
  function automatic logic [10:0] guard_cob(input logic [6:0] node);
    guard_cob = GUARD_COB_BASE + {4'h0, node};
  endfunction

  // both factors widened first so the product keeps all of its bits
  function automatic logic [WIN_W-1:0] win_ms(input logic [15:0] ivl, input logic [7:0] mult);
    win_ms = WIN_W'(ivl) * WIN_W'(mult);
  endfunction

  // drive parameters occupy one contiguous index range
  function automatic logic in_drive_range(input logic [15:0] idx);
    in_drive_range = (idx >= IDX_DRIVE_FIRST) && (idx <= IDX_DRIVE_LAST);
  endfunction

  logic beat_off;
  logic peer_off;
  logic interval_set;
  logic mult_set;
  logic watch_on;
  logic cfg_ok;
  logic guard_query;
  logic reply_busy;
  logic expire_hit;
  logic is_drive;
  logic [31:0] lim_in;

  always_comb begin
    beat_off = (s_q.beat_send_period == RST_BEAT_SEND);
    peer_off = (s_q.peer_beat_watch_cfg == RST_PEER_BEAT);
    interval_set = (s_q.guard_interval_ms != RST_GUARD_INTERVAL);
    mult_set = (s_q.guard_multiplier != RST_GUARD_MULT);
    watch_on = flt_nonzero(s_q.link_watch_enable);
    cfg_ok = beat_off && peer_off && interval_set && mult_set;
    guard_query = RX_VALID && RX_RTR && (RX_DLC == GUARD_QUERY_DLC)
      && (RX_ID == guard_cob(NODE_ID));
    // a reply still waiting for the transmitter blocks the next one
    reply_busy = s_q.tx_valid && !TX_READY;
    // guarding alone never trips; the enable object must be set as well
    expire_hit = tif.expire && s_q.armed && watch_on;
    is_drive = in_drive_range(OBJ_IDX);
    lim_in = flt_clamp(OBJ_WDATA, FLT_CUR_LIMIT_MAX);
  end

  always_comb begin
    s_d = s_q;
    s_d.kick = 1'b0;
    s_d.obj_ack = 1'b0;
    s_d.obj_abort = 1'b0;
    s_d.nvm_wr = 1'b0;

    // reply path; a query arriving while a reply waits is still counted as a kick
    if (s_q.tx_valid && TX_READY) begin
      s_d.tx_valid = 1'b0;
    end
    if (guard_query && !reply_busy) begin
      s_d.tx_valid = 1'b1;
      s_d.tx_id = guard_cob(NODE_ID);
      s_d.tx_data = {s_q.toggle, NODE_STATE};
      s_d.toggle = ~s_q.toggle;
    end

    // arming: the first query after configuration starts the window
    if (!cfg_ok) begin
      s_d.armed = 1'b0;
    end else if (guard_query) begin
      s_d.armed = 1'b1;
      s_d.kick = 1'b1;
    end
    s_d.run = s_d.armed;

    // timeout raises the error; a new expiry outranks a same-cycle acknowledge
    if (ERR_ACK) begin
      s_d.tmo_err = 1'b0;
    end
    if (expire_hit) begin
      s_d.tmo_err = 1'b1;
    end

    // object access, answered one cycle after the request
    if (OBJ_REQ) begin
      s_d.obj_ack = 1'b1;
      s_d.obj_rdata = FLT_ZERO;
      if (OBJ_PDO) begin
        s_d.obj_abort = 1'b1;
      end else begin
        case (OBJ_IDX)
          IDX_GUARD_INTERVAL: begin
            s_d.obj_rdata = {16'h0000, s_q.guard_interval_ms};
            if (OBJ_WR) begin
              s_d.guard_interval_ms = OBJ_WDATA[15:0];
            end
          end
          IDX_GUARD_MULT: begin
            s_d.obj_rdata = {24'h000000, s_q.guard_multiplier};
            if (OBJ_WR) begin
              s_d.guard_multiplier = OBJ_WDATA[7:0];
            end
          end
          IDX_PEER_BEAT: begin
            if (OBJ_SUB == SUB_PEER_ENTRY) begin
              s_d.obj_rdata = s_q.peer_beat_watch_cfg;
              if (OBJ_WR) begin
                s_d.peer_beat_watch_cfg = OBJ_WDATA;
              end
            end else if (OBJ_SUB == SUB_ZERO && !OBJ_WR) begin
              s_d.obj_rdata = PEER_BEAT_COUNT;
            end else begin
              s_d.obj_abort = 1'b1;
            end
          end
          IDX_BEAT_SEND: begin
            s_d.obj_rdata = {16'h0000, s_q.beat_send_period};
            if (OBJ_WR) begin
              s_d.beat_send_period = OBJ_WDATA[15:0];
            end
          end
          IDX_CUR_LIMIT: begin
            s_d.obj_rdata = s_q.motor_current_limit_pct;
            if (OBJ_WR) begin
              s_d.motor_current_limit_pct = lim_in;
              s_d.nvm_wr = 1'b1;
              s_d.nvm_idx = OBJ_IDX;
              s_d.nvm_data = lim_in;
            end
          end
          IDX_LINK_WATCH: begin
            s_d.obj_rdata = s_q.link_watch_enable;
            if (OBJ_WR) begin
              s_d.link_watch_enable = OBJ_WDATA;
              s_d.nvm_wr = 1'b1;
              s_d.nvm_idx = OBJ_IDX;
              s_d.nvm_data = OBJ_WDATA;
            end
          end
          default: begin
            // other drive parameters live outside this block
            s_d.obj_abort = 1'b1;
          end
        endcase
        if (!is_drive && OBJ_IDX[15:12] == IDX_DRIVE_FIRST[15:12]) begin
          s_d.obj_abort = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.toggle <= 1'b0;
      s_q.armed <= 1'b0;
      s_q.tmo_err <= 1'b0;
      s_q.tx_valid <= 1'b0;
      s_q.guard_interval_ms <= RST_GUARD_INTERVAL;
      s_q.guard_multiplier <= RST_GUARD_MULT;
      s_q.peer_beat_watch_cfg <= RST_PEER_BEAT;
      s_q.beat_send_period <= RST_BEAT_SEND;
      s_q.motor_current_limit_pct <= RST_CUR_LIMIT;
      s_q.link_watch_enable <= RST_LINK_WATCH;
    end else begin
      s_q <= s_d;
    end
  end

  // window is interval times factor, all in milliseconds
  assign tif.window_ms = win_ms(s_q.guard_interval_ms, s_q.guard_multiplier);
  assign tif.run = s_q.run;
  assign tif.kick = s_q.kick;

  // reply frame
  assign TX_VALID = s_q.tx_valid;
  assign TX_ID = s_q.tx_id;
  assign TX_DATA = s_q.tx_data;

  // object answer and commit
  assign OBJ_ACK = s_q.obj_ack;
  assign OBJ_ABORT = s_q.obj_abort;
  assign OBJ_RDATA = s_q.obj_rdata;
  assign NVM_WR = s_q.nvm_wr;
  assign NVM_IDX = s_q.nvm_idx;
  assign NVM_DATA = s_q.nvm_data;

  // stop shares the error flop so the two never part
  assign BUS_TMO_ERR = s_q.tmo_err;
  assign MOTOR_STOP = s_q.tmo_err;
  assign GUARD_ARMED = s_q.armed;

endmodule
`default_nettype wire

/* File: tb/cng_node_guard_props.sv */
// assertions on the node guard monitor ports
// assumes bind into cng_node_guard, single core clock
`timescale 1ns/1ps
`default_nettype none
module cng_node_guard_props
  import cng_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [6:0] NODE_ID,
  input wire logic RX_VALID,
  input wire logic [10:0] RX_ID,
  input wire logic RX_RTR,
  input wire logic [3:0] RX_DLC,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [10:0] TX_ID,
  input wire logic [7:0] TX_DATA,
  input wire logic OBJ_REQ,
  input wire logic OBJ_WR,
  input wire logic OBJ_PDO,
  input wire logic [15:0] OBJ_IDX,
  input wire logic [31:0] OBJ_WDATA,
  input wire logic OBJ_ACK,
  input wire logic OBJ_ABORT,
  input wire logic NVM_WR,
  input wire logic [15:0] NVM_IDX,
  input wire logic [31:0] NVM_DATA,
  input wire logic ERR_ACK,
  input wire logic BUS_TMO_ERR,
  input wire logic MOTOR_STOP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  wire logic [10:0] own = GUARD_COB_BASE + {4'h0, NODE_ID};
  wire logic hit = RX_VALID && RX_RTR && RX_DLC == GUARD_QUERY_DLC && RX_ID == own;
  property p_reply; hit && !TX_VALID |-> ##[1:2] TX_VALID && TX_ID == own; endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  a_hold: assert property (p_hold) else $error("reply dropped");
  property p_ack; OBJ_REQ |-> ##[1:2] OBJ_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_pdo; OBJ_REQ && OBJ_PDO |-> ##[1:2] OBJ_ABORT && !NVM_WR; endproperty
  a_pdo: assert property (p_pdo) else $error("pdo taken");
  property p_clamp; NVM_WR && NVM_IDX == IDX_CUR_LIMIT |-> NVM_DATA <= FLT_CUR_LIMIT_MAX; endproperty
  a_clamp: assert property (p_clamp) else $error("limit out");
  property p_commit;
    OBJ_REQ && OBJ_WR && !OBJ_PDO && OBJ_IDX == IDX_LINK_WATCH
      |=> NVM_WR && NVM_DATA == $past(OBJ_WDATA);
  endproperty
  a_commit: assert property (p_commit) else $error("no commit");
  property p_stop; MOTOR_STOP == BUS_TMO_ERR; endproperty
  a_stop: assert property (p_stop) else $error("stop differs");
  property p_clear; BUS_TMO_ERR && ERR_ACK |=> !BUS_TMO_ERR; endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  c_reply: cover property (TX_VALID && TX_READY);
  c_tmo: cover property ($rose(BUS_TMO_ERR));
  c_nvm: cover property (NVM_WR && NVM_IDX == IDX_CUR_LIMIT);
endmodule
`default_nettype wire

/* File: tb/cng_master_model.sv */
// polling master: guard queries out, replies taken with random stall
// assumes query is called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cng_master_model (
  input wire logic CORE_CLK,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic RX_VALID,
  output logic [10:0] RX_ID,
  output logic RX_RTR,
  output logic [3:0] RX_DLC
);
  logic [31:0] s = 32'd78471;
  // raised by the bench to hold a reply pending
  logic stall = 1'b0;
  logic [1:0] w = 2'h0;
  initial begin
    TX_READY = 1'b0;
    RX_VALID = 1'b0;
    RX_ID = 11'h0;
    RX_RTR = 1'b0;
    RX_DLC = 4'h0;
  end
  // stall 0 to 3 cycles so slow and prompt takes both occur
  always @(posedge CORE_CLK) begin
    #1;
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    TX_READY = TX_VALID && w == 2'h0 && !stall;
    w = TX_VALID ? (w == 2'h0 ? w : w - 2'h1) : s[1:0];
  end
  // released lines flip so stale values never look valid
  task automatic query(input logic [10:0] id);
    RX_VALID = 1'b1;
    RX_ID = id;
    RX_RTR = 1'b1;
    RX_DLC = 4'h0;
    @(posedge CORE_CLK);
    #1;
    RX_VALID = 1'b0;
    RX_ID = ~id;
    RX_RTR = 1'b0;
    RX_DLC = 4'hf;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// bench of the node guard monitor with the polling master model
// assumes TICK_CYCLES cut to 4 so one ms is 4 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cng_pkg::*;
  localparam int TK = 4;
  localparam int W = 2 * 3 * TK;
  logic CORE_CLK, RST_B = 1'b0, OBJ_REQ = 1'b0, OBJ_WR = 1'b0, OBJ_PDO = 1'b0, ERR_ACK = 1'b0;
  logic [6:0] NODE_ID = 7'h1, NODE_STATE = 7'h0;
  logic [15:0] OBJ_IDX = 16'h0, NVM_IDX;
  logic [7:0] OBJ_SUB = 8'h0, TX_DATA;
  logic [7:0] sb = SUB_PEER_ENTRY;
  logic [31:0] OBJ_WDATA = 32'h0, x = 32'd78471, rd, d, OBJ_RDATA, NVM_DATA;
  logic RX_VALID, RX_RTR, TX_VALID, TX_READY, OBJ_ACK, OBJ_ABORT, NVM_WR, ab, nv, tg;
  logic BUS_TMO_ERR, MOTOR_STOP, GUARD_ARMED;
  logic [10:0] RX_ID, TX_ID;
  logic [3:0] RX_DLC;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, qc = 0;
  logic [15:0] ci [5] = '{IDX_GUARD_INTERVAL, IDX_GUARD_MULT, IDX_PEER_BEAT, IDX_BEAT_SEND,
    IDX_LINK_WATCH};
  logic [31:0] cv [5] = '{32'h2, 32'h3, 32'h0, 32'h0, 32'h3f80_0000};
  logic [31:0] bad [5] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0};
  wire logic [10:0] own = GUARD_COB_BASE + {4'h0, NODE_ID};
  cng_node_guard #(.TICK_CYCLES(TK)) cng_node_guard_inst (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .NODE_ID(NODE_ID),
    .NODE_STATE(NODE_STATE),
    .RX_VALID(RX_VALID),
    .RX_ID(RX_ID),
    .RX_RTR(RX_RTR),
    .RX_DLC(RX_DLC),
    .TX_VALID(TX_VALID),
    .TX_READY(TX_READY),
    .TX_ID(TX_ID),
    .TX_DATA(TX_DATA),
    .OBJ_REQ(OBJ_REQ),
    .OBJ_WR(OBJ_WR),
    .OBJ_PDO(OBJ_PDO),
    .OBJ_IDX(OBJ_IDX),
    .OBJ_SUB(OBJ_SUB),
    .OBJ_WDATA(OBJ_WDATA),
    .OBJ_ACK(OBJ_ACK),
    .OBJ_ABORT(OBJ_ABORT),
    .OBJ_RDATA(OBJ_RDATA),
    .NVM_WR(NVM_WR),
    .NVM_IDX(NVM_IDX),
    .NVM_DATA(NVM_DATA),
    .ERR_ACK(ERR_ACK),
    .BUS_TMO_ERR(BUS_TMO_ERR),
    .MOTOR_STOP(MOTOR_STOP),
    .GUARD_ARMED(GUARD_ARMED)
  );
  cng_master_model cng_master_model_inst (
    .CORE_CLK(CORE_CLK),
    .TX_VALID(TX_VALID),
    .TX_READY(TX_READY),
    .RX_VALID(RX_VALID),
    .RX_ID(RX_ID),
    .RX_RTR(RX_RTR),
    .RX_DLC(RX_DLC)
  );
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  function automatic void rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
  endfunction
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return v[FLT_SIGN] ? FLT_ZERO : (v > FLT_CUR_LIMIT_MAX ? FLT_CUR_LIMIT_MAX : v);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic obj(input logic wr, input logic pdo, input logic [15:0] i, input logic [31:0] v);
    OBJ_WR = wr;
    OBJ_PDO = pdo;
    OBJ_IDX = i;
    OBJ_SUB = sb;
    OBJ_WDATA = v;
    OBJ_REQ = 1'b1;
    tick(1);
    OBJ_REQ = 1'b0;
    for (int k = 0; k < 4 && OBJ_ACK !== 1'b1; k++) tick(1);
    chk({31'h0, OBJ_ACK}, 32'h1);
    rd = OBJ_RDATA;
    ab = OBJ_ABORT;
    nv = NVM_WR;
    tick(1);
  endtask
  task automatic q(input logic good);
    rnd();
    NODE_STATE = x[1] ? (x[0] ? 7'h7f : 7'h05) : (x[0] ? 7'h04 : 7'h00);
    qc = cyc + 1;
    cng_master_model_inst.query(own + {10'h0, !good});
    for (int k = 0; k < 4 && TX_VALID !== 1'b1; k++) tick(1);
    if (good) begin
      chk({12'h0, TX_VALID, TX_ID, TX_DATA}, {12'h0, 1'b1, own, tg, NODE_STATE});
      for (int k = 0; k < 8 && TX_VALID === 1'b1; k++) tick(1);
      tg = ~tg;
    end else chk({31'h0, TX_VALID}, 32'h0);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // run is about five hundred cycles; forty times that is a hang
  initial begin
    #80000;
    n_mismatch++;
    close_out();
  end
  initial begin
    rnd();
    NODE_ID = x[6:0] | 7'h01;
    tg = 1'b0;
    tick(6);
    RST_B = 1'b1;
    foreach (ci[i]) begin
      obj(1'b0, 1'b0, ci[i], 32'h0);
      chk(rd, 32'h0);
    end
    // entry count of the consumer object reads back, but cannot be written
    sb = SUB_ZERO;
    obj(1'b0, 1'b0, IDX_PEER_BEAT, 32'h0);
    chk({31'h0, ab}, 32'h0);
    chk(rd, PEER_BEAT_COUNT);
    obj(1'b1, 1'b0, IDX_PEER_BEAT, 32'h5);
    chk({31'h0, ab}, 32'h1);
    sb = SUB_PEER_ENTRY;
    obj(1'b1, 1'b1, IDX_CUR_LIMIT, 32'h42c8_0000);
    chk({30'h0, ab, nv}, 32'h2);
    obj(1'b0, 1'b0, IDX_CUR_LIMIT, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      rnd();
      d = i == 0 ? 32'h43c8_0000 : i == 1 ? 32'hbf80_0000 : {x[31], 7'h43, x[23:0]};
      obj(1'b1, 1'b0, IDX_CUR_LIMIT, d);
      chk({15'h0, nv, NVM_IDX}, {15'h0, 1'b1, IDX_CUR_LIMIT});
      chk(NVM_DATA, clamp(d));
      obj(1'b0, 1'b0, IDX_CUR_LIMIT, 32'h0);
      chk(rd, clamp(d));
    end
    foreach (ci[i]) obj(1'b1, 1'b0, ci[i], cv[i]);
    repeat (3) q(1'b1);
    q(1'b0);
    chk({31'h0, GUARD_ARMED}, 32'h1);
    // a query while the reply waits gets no reply and no toggle flip
    cng_master_model_inst.stall = 1'b1;
    q(1'b1);
    d = {24'h0, TX_DATA};
    cng_master_model_inst.query(own);
    tick(2);
    chk({24'h0, TX_DATA}, d);
    cng_master_model_inst.stall = 1'b0;
    for (int k = 0; k < 8 && TX_VALID === 1'b1; k++) tick(1);
    q(1'b1);
    repeat (4) begin
      tick(12);
      q(1'b1);
    end
    chk({31'h0, BUS_TMO_ERR}, 32'h0);
    for (int k = 0; k < 60 && BUS_TMO_ERR !== 1'b1; k++) tick(1);
    chk({31'h0, cyc >= qc + W + 2 && cyc <= qc + W + 8}, 32'h1);
    chk({31'h0, MOTOR_STOP}, 32'h1);
    ERR_ACK = 1'b1;
    tick(1);
    ERR_ACK = 1'b0;
    chk({31'h0, BUS_TMO_ERR}, 32'h0);
    // each pass spoils one setting of an otherwise good set
    for (int i = 0; i < 5; i++) begin
      foreach (ci[j]) obj(1'b1, 1'b0, ci[j], cv[j]);
      obj(1'b1, 1'b0, ci[i], bad[i]);
      q(1'b1);
      tick(40);
      chk({31'h0, BUS_TMO_ERR}, 32'h0);
      if (i < 4) chk({31'h0, GUARD_ARMED}, 32'h0);
    end
    close_out();
  end
endmodule
bind cng_node_guard cng_node_guard_props cng_node_guard_props_inst (
  .CORE_CLK(CORE_CLK),
  .RST_B(RST_B),
  .NODE_ID(NODE_ID),
  .RX_VALID(RX_VALID),
  .RX_ID(RX_ID),
  .RX_RTR(RX_RTR),
  .RX_DLC(RX_DLC),
  .TX_VALID(TX_VALID),
  .TX_READY(TX_READY),
  .TX_ID(TX_ID),
  .TX_DATA(TX_DATA),
  .OBJ_REQ(OBJ_REQ),
  .OBJ_WR(OBJ_WR),
  .OBJ_PDO(OBJ_PDO),
  .OBJ_IDX(OBJ_IDX),
  .OBJ_WDATA(OBJ_WDATA),
  .OBJ_ACK(OBJ_ACK),
  .OBJ_ABORT(OBJ_ABORT),
  .NVM_WR(NVM_WR),
  .NVM_IDX(NVM_IDX),
  .NVM_DATA(NVM_DATA),
  .ERR_ACK(ERR_ACK),
  .BUS_TMO_ERR(BUS_TMO_ERR),
  .MOTOR_STOP(MOTOR_STOP)
);
`default_nettype wire
